// ### hw/soe_pkg.sv
// sync output enable / polarity block: shared constants, field layout and carrier types
// assumes a 32-bit AXI4-Lite register bus and one system clock
package soe_pkg;

  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] SOE_OFS_OUT_CTRL = 8'h00; // sync_output_control
  localparam logic [7:0] SOE_OFS_IN_CTRL  = 8'h04; // sync_input_control
  localparam logic [7:0] SOE_OFS_STATUS   = 8'h08; // read-only pin state

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int SOE_BIT_HORIZ_EN    = 7;
  localparam int SOE_BIT_VERT_EN     = 6;
  localparam int SOE_BIT_CLAMP_EN    = 5;
  localparam int SOE_BIT_BLANK_EN    = 4;
  localparam int SOE_BIT_HORIZ_INV   = 3;
  localparam int SOE_BIT_VERT_INV    = 2;
  localparam int SOE_BIT_CLAMP_INV   = 1;
  localparam int SOE_BIT_BLANK_INV   = 0;
  localparam int SOE_BIT_CONNECT     = 5; // sync_connect_mode in sync_input_control
  localparam int SOE_STAT_OUT_LSB    = 0;
  localparam int SOE_STAT_OE_LSB     = 4;
  localparam int SOE_STAT_MODE_LSB   = 8;

  // ***************************************************************
  // reset values and codes
  // ***************************************************************
  localparam logic [7:0] SOE_RST_OUT_CTRL = 8'h00;
  localparam logic       SOE_RST_CONNECT  = 1'b0;
  localparam logic [1:0] SOE_RESP_OKAY    = 2'h0;
  localparam logic [1:0] SOE_RESP_SLVERR  = 2'h2;
  localparam logic [1:0] SOE_MODE_ONE     = 2'h1; // blanking pin stays address line
  localparam logic [1:0] SOE_STRAP_WAIT   = 2'h2; // edges after release before strap capture

  // the four shared output pins, one bit each
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic clamp;
    logic blank;
  } soe_pin4_t;

  // timer input group, pin side or internal-sync side
  typedef struct packed {
    logic frtA;
    logic frtB;
    logic frtC;
    logic frtD;
    logic tmrClk1;
    logic tmrRst1;
  } soe_tmrin_t;

  // internal sync signals that may replace timer pin inputs
  typedef struct packed {
    logic internalVertIn;
    logic internalHorizIn;
    logic tmrOut1;
    logic spareVertIn;
  } soe_syncint_t;

endpackage : soe_pkg

// ### hw/soe_pin_cell.sv
// one shared output pin: chooses the sync function or the fallback function
// assumes all inputs come from logic on ref_clk
`timescale 1ns/1ps
module soe_pin_cell
  import soe_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic invert,
  input  wire logic syncSrc,
  input  wire logic fbOut,
  input  wire logic fbOe,
  output logic      pinOut,
  output logic      pinOe
);

  // ***************************************************************
  // registered pin drive
  // ***************************************************************
  // sync function drives the pin outright; otherwise port/timer/pwm settings rule
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pinOut <= 1'b0;
      pinOe  <= 1'b0;
    end
    else if (enable)
    begin
      pinOut <= syncSrc ^ invert;
      pinOe  <= 1'b1;
    end
    else
    begin
      pinOut <= fbOut;
      pinOe  <= fbOe;
    end
  end

endmodule : soe_pin_cell

// ### hw/soe_sync_out.sv
// sync output enable / polarity block with an AXI4-Lite register slave
// assumes one clock; pin inputs and the mode strap are asynchronous to it
`timescale 1ns/1ps
module soe_sync_out
  import soe_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // operating mode strap pins
  input  wire logic [1:0]        opModeStrap,
  // internal sync waveforms
  input  wire logic              internalHorizOut,
  input  wire logic              internalVertOut,
  input  wire logic              clampSource,
  input  wire logic              blankingWave,
  // fallback functions of the shared pins (port, timer, pwm, address line)
  input  soe_pkg::soe_pin4_t     fallbackOut,
  input  soe_pkg::soe_pin4_t     fallbackOe,
  // shared pin drive
  output soe_pkg::soe_pin4_t     syncPinOut,
  output soe_pkg::soe_pin4_t     syncPinOe,
  // timer inputs: raw pins, internal sources, selected result
  input  soe_pkg::soe_tmrin_t    timerPinIn,
  input  soe_pkg::soe_syncint_t  syncInternal,
  output soe_pkg::soe_tmrin_t    timerIn
);
  import soe_pkg::*;

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (ADDR_W < 4 || ADDR_W > 32)
  begin : gBadAddr
    $error("soe_sync_out: ADDR_W must lie in 4..32");
  end

  // ***************************************************************
  // control state
  // ***************************************************************
  logic [7:0]  outCtrl_r;      // sync_output_control
  logic        connectMode_r;  // sync_connect_mode
  logic [1:0]  strapSync1_r;
  logic [1:0]  strapSync2_r;
  logic [1:0]  opMode_r;
  logic [1:0]  strapCnt_r;
  logic        strapDone_r;
  soe_tmrin_t  timerSync1_r;
  soe_tmrin_t  timerSync2_r;
  // write and read channel state
  logic [7:0]  awAddr_r;
  logic        awHeld_r;
  logic [7:0]  wData_r;
  logic        wLane0_r;
  logic        wHeld_r;
  logic        wrFire;
  logic        wrHit;
  logic [7:0]  arAddr;
  logic [7:0]  awAddrIn;
  logic [31:0] rdValue;
  logic        rdHit;

  assign awAddrIn = 8'(s_axi_awaddr);
  assign arAddr   = 8'(s_axi_araddr);

  // ***************************************************************
  // mode strap capture
  // ***************************************************************
  // strap pins are asynchronous: two flops, then latched once a few edges after release;
  // mode is frozen after capture, so changing straps later has no effect
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strapSync1_r <= 2'h0;
      strapSync2_r <= 2'h0;
      strapCnt_r   <= 2'h0;
      strapDone_r  <= 1'b0;
      opMode_r     <= 2'h0;
    end
    else
    begin
      strapSync1_r <= opModeStrap;
      strapSync2_r <= strapSync1_r;
      if (!strapDone_r && strapCnt_r == SOE_STRAP_WAIT)
      begin
        opMode_r    <= strapSync2_r;
        strapDone_r <= 1'b1;
      end
      else if (!strapDone_r)
      begin
        strapCnt_r <= strapCnt_r + 2'h1;
      end
    end
  end

  // ***************************************************************
  // AXI4-Lite write path
  // ***************************************************************
  // address and data are taken in either order; response follows both
  assign wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wrHit  = (awAddr_r == SOE_OFS_OUT_CTRL) || (awAddr_r == SOE_OFS_IN_CTRL)
                  || (awAddr_r == SOE_OFS_STATUS);
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_awready <= 1'b1;
      awHeld_r      <= 1'b0;
      awAddr_r      <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awAddr_r      <= awAddrIn;
      awHeld_r      <= 1'b1;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      awHeld_r      <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_wready <= 1'b1;
      wHeld_r      <= 1'b0;
      wData_r      <= 8'h00;
      wLane0_r     <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wData_r      <= s_axi_wdata[7:0];
      wLane0_r     <= s_axi_wstrb[0];
      wHeld_r      <= 1'b1;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      wHeld_r      <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // status is read-only: a write there is accepted and ignored
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SOE_RESP_OKAY;
    end
    else if (wrFire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? SOE_RESP_OKAY : SOE_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ***************************************************************
  // control registers
  // ***************************************************************
  // only byte lane 0 carries register bits; other lanes are dropped
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      outCtrl_r     <= SOE_RST_OUT_CTRL;
      connectMode_r <= SOE_RST_CONNECT;
    end
    else if (wrFire && wLane0_r)
    begin
      if (awAddr_r == SOE_OFS_OUT_CTRL)
      begin
        outCtrl_r <= wData_r;
      end
      if (awAddr_r == SOE_OFS_IN_CTRL)
      begin
        connectMode_r <= wData_r[SOE_BIT_CONNECT];
      end
    end
  end

  // ***************************************************************
  // AXI4-Lite read path
  // ***************************************************************
  always_comb
  begin
    rdValue = 32'h0000_0000;
    rdHit   = 1'b1;
    unique case (arAddr)
      SOE_OFS_OUT_CTRL: rdValue[7:0] = outCtrl_r;
      SOE_OFS_IN_CTRL:  rdValue[SOE_BIT_CONNECT] = connectMode_r;
      SOE_OFS_STATUS:
      begin
        rdValue[SOE_STAT_OUT_LSB +: 4]  = syncPinOut;
        rdValue[SOE_STAT_OE_LSB +: 4]   = syncPinOe;
        rdValue[SOE_STAT_MODE_LSB +: 2] = opMode_r;
      end
      default:          rdHit = 1'b0;
    endcase
  end

  // one read at a time; arready drops until the data is taken
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= SOE_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdValue;
      s_axi_rresp   <= rdHit ? SOE_RESP_OKAY : SOE_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ***************************************************************
  // shared output pins
  // ***************************************************************
  soe_pin4_t enVec;
  soe_pin4_t invVec;
  soe_pin4_t srcVec;
  // blanking pin is held as address line in mode 1 whatever its enable says
  assign enVec.hsync  = outCtrl_r[SOE_BIT_HORIZ_EN];
  assign enVec.vsync  = outCtrl_r[SOE_BIT_VERT_EN];
  assign enVec.clamp  = outCtrl_r[SOE_BIT_CLAMP_EN];
  assign enVec.blank  = outCtrl_r[SOE_BIT_BLANK_EN]
                        && (opMode_r != SOE_MODE_ONE);
  assign invVec = outCtrl_r[SOE_BIT_HORIZ_INV:SOE_BIT_BLANK_INV];
  assign srcVec = {internalHorizOut, internalVertOut, clampSource, blankingWave};

  // one cell per pin; each adds one register stage from control to pad
  for (genvar i = 0; i < 4; i++)
  begin : gPin
    soe_pin_cell uCell (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .enable  (enVec[i]),
      .invert  (invVec[i]),
      .syncSrc (srcVec[i]),
      .fbOut   (fallbackOut[i]),
      .fbOe    (fallbackOe[i]),
      .pinOut  (syncPinOut[i]),
      .pinOe   (syncPinOe[i])
    );
  end

  // ***************************************************************
  // timer input selection
  // ***************************************************************
  // pin inputs cross into this clock through two flops before selection
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timerSync1_r <= '0;
      timerSync2_r <= '0;
    end
    else
    begin
      timerSync1_r <= timerPinIn;
      timerSync2_r <= timerSync1_r;
    end
  end

  // output enables are deliberately absent here: only connect mode steers inputs
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      timerIn <= '0;
    end
    else if (connectMode_r)
    begin
      timerIn <= {syncInternal.internalVertIn, syncInternal.tmrOut1, syncInternal.spareVertIn,
                  syncInternal.internalHorizIn, syncInternal.internalHorizIn,
                  ~syncInternal.internalVertIn};
    end
    else
    begin
      timerIn <= timerSync2_r;
    end
  end

endmodule : soe_sync_out

// ### bench/soe_sync_out_checker.sv
// checker for the sync output block: pin drive, timer inputs and bus answers
// assumes it is bound to soe_sync_out and sees its ports only
`timescale 1ns/1ps
module soe_sync_out_checker
#(
  parameter int ADDR_W = 8
)
(
  input wire logic              ref_clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [1:0]        opModeStrap,
  input wire logic              internalHorizOut,
  input wire logic              internalVertOut,
  input wire logic              clampSource,
  input wire logic              blankingWave,
  input soe_pkg::soe_pin4_t     fallbackOut,
  input soe_pkg::soe_pin4_t     fallbackOe,
  input soe_pkg::soe_pin4_t     syncPinOut,
  input soe_pkg::soe_pin4_t     syncPinOe,
  input soe_pkg::soe_tmrin_t    timerPinIn,
  input soe_pkg::soe_syncint_t  syncInternal,
  input soe_pkg::soe_tmrin_t    timerIn
);
  import soe_pkg::*;
  logic [7:0] wAddr_r;
  logic [8:0] wDat_r;
  logic [7:0] ctl_r;
  logic       conn_r;
  logic       bvQ_r;
  logic [3:0] siQ_r;
  logic [2:0] up_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // register shadow
  // ****************************************
  // shadow lags the slave by one edge, which lines it up with the pin register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {wAddr_r, wDat_r, ctl_r, conn_r, bvQ_r} <= '0;
    end
    else
    begin
      bvQ_r <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) wAddr_r <= s_axi_awaddr[7:0];
      if (s_axi_wvalid && s_axi_wready) wDat_r <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
      if (s_axi_bvalid && !bvQ_r && s_axi_bresp == SOE_RESP_OKAY && wDat_r[8])
      begin
        if (wAddr_r == SOE_OFS_OUT_CTRL) ctl_r <= wDat_r[7:0];
        if (wAddr_r == SOE_OFS_IN_CTRL) conn_r <= wDat_r[SOE_BIT_CONNECT];
      end
    end
  end
  // internal sync copy and a saturating age count; pins are judged only once out of reset,
  // since the first edge after release still shows the reset drive, not the fallback
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      {siQ_r, up_r} <= '0;
    else
      {siQ_r, up_r} <= {syncInternal, (up_r == 3'h7) ? up_r : up_r + 3'h1};
  end
  // ****************************************
  // assertions
  // ****************************************
  chk_horiz_pin: assert property (up_r != 3'h0 |=>
    syncPinOut.hsync == (ctl_r[7] ? $past(internalHorizOut) ^ ctl_r[3] : $past(fallbackOut.hsync))
    && syncPinOe.hsync == (ctl_r[7] | $past(fallbackOe.hsync))) else $error("hsync pin wrong");
  chk_vert_pin: assert property (up_r != 3'h0 |=>
    syncPinOut.vsync == (ctl_r[6] ? $past(internalVertOut) ^ ctl_r[2] : $past(fallbackOut.vsync))
    && syncPinOe.vsync == (ctl_r[6] | $past(fallbackOe.vsync))) else $error("vsync pin wrong");
  chk_clamp_pin: assert property (up_r != 3'h0 |=>
    syncPinOut.clamp == (ctl_r[5] ? $past(clampSource) ^ ctl_r[1] : $past(fallbackOut.clamp))
    && syncPinOe.clamp == (ctl_r[5] | $past(fallbackOe.clamp))) else $error("clamp pin wrong");
  chk_blank_pin: assert property (up_r != 3'h0 |=>
    syncPinOut.blank == ((ctl_r[4] && opModeStrap != SOE_MODE_ONE) ?
      $past(blankingWave) ^ ctl_r[0] : $past(fallbackOut.blank))
    && syncPinOe.blank == ((ctl_r[4] && opModeStrap != SOE_MODE_ONE) | $past(fallbackOe.blank)))
    else $error("blank pin wrong");
  chk_timer_sync: assert property (conn_r |->
    timerIn == {siQ_r[3], siQ_r[1], siQ_r[0], siQ_r[2], siQ_r[2], !siQ_r[3]})
    else $error("internal timer source wrong");
  chk_timer_pins: assert property (!conn_r && up_r == 3'h7 |->
    timerIn == $past(timerPinIn, 3)) else $error("timer pin path wrong");
  chk_ctl_readback: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == SOE_OFS_OUT_CTRL
    |=> s_axi_rvalid && s_axi_rdata[7:0] == ctl_r) else $error("control readback wrong");
  chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h02
    |=> s_axi_rresp == SOE_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule : soe_sync_out_checker

bind soe_sync_out soe_sync_out_checker #(.ADDR_W(ADDR_W)) soe_sync_out_checker_inst (.*);

// ### bench/soe_video_sink.sv
// model of the video circuitry fed by the four shared pins
// assumes no pull resistor, so an undriven pin drifts away from its last level
`timescale 1ns/1ps
module soe_video_sink
(
  input wire logic           ref_clk,
  input soe_pkg::soe_pin4_t  syncPinOut,
  input soe_pkg::soe_pin4_t  syncPinOe,
  output soe_pkg::soe_pin4_t pinLevel
);
  import soe_pkg::*;
  logic [3:0] last_r = 4'h0;
  // undriven pins show the inverse of the last level, so no stale value can pass
  always_ff @(posedge ref_clk)
    last_r <= pinLevel;
  assign pinLevel = (syncPinOut & syncPinOe) | (~last_r & ~syncPinOe);
endmodule : soe_video_sink

// ### bench/sync_output_enable_polarity_tb_top.sv
// top bench: bus master tasks and one task per scenario for the sync output block
// assumes the checker binds itself and the sink model watches the pins
`timescale 1ns/1ps
module sync_output_enable_polarity_tb_top;
  import soe_pkg::*;
  logic        ref_clk = 1'b0, nrst = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, opModeStrap = 2'h2;
  logic        internalHorizOut = 1'b0, internalVertOut = 1'b0;
  logic        clampSource = 1'b0, blankingWave = 1'b0;
  soe_pin4_t   fallbackOut = 4'h0, fallbackOe = 4'h0, syncPinOut, syncPinOe, pinLevel;
  soe_tmrin_t  timerPinIn = 6'h00, timerIn;
  soe_syncint_t syncInternal = 4'h0;
  int          failures = 0, num_checks = 0;
  // 25 MHz system clock
  always #20 ref_clk = ~ref_clk;
  soe_sync_out soe_sync_out_inst (.*);
  soe_video_sink soe_video_sink_inst (.*);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // a stuck handshake counts as a mismatch and ends the run
  task automatic guard(input int n);
    if (n > 40)
    begin
      $display("MISMATCH at %0t: handshake timed out", $time);
      failures++;
      close_out();
    end
  endtask : guard
  task automatic settle(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic do_reset(input logic [1:0] m);
    @(posedge ref_clk);
    nrst <= 1'b0;
    opModeStrap <= m;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask : do_reset
  // address and data offered together; ready values are read before the edge lands
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge ref_clk);
      guard(++n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check(32'(s_axi_bresp), 32'(r));
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge ref_clk);
      guard(++n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    check(s_axi_rdata, d);
    check(32'(s_axi_rresp), 32'(r));
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values;
    axi_rd(SOE_OFS_OUT_CTRL, 32'h0, SOE_RESP_OKAY);
    axi_rd(SOE_OFS_IN_CTRL, 32'h0, SOE_RESP_OKAY);
    check(32'(syncPinOe), 32'h0);
  endtask : t_reset_values
  // one enable at a time, plain then inverted; waveforms and fallback disagree on every pin
  task automatic t_pin_select;
    logic [3:0] m, e;
    logic [7:0] c;
    @(posedge ref_clk);
    {internalHorizOut, internalVertOut, clampSource, blankingWave} <= 4'hA;
    fallbackOut <= 4'h5;
    for (int i = 0; i < 8; i++)
    begin
      m = 4'h1 << (i % 4);
      e = ((4'hA ^ (i > 3 ? m : 4'h0)) & m) | (4'h5 & ~m);
      c = (i > 3 ? 8'h11 : 8'h10) << (i % 4);
      axi_wr(SOE_OFS_OUT_CTRL, c, SOE_RESP_OKAY);
      settle(1);
      check(32'(syncPinOut), 32'(e));
      check(32'(syncPinOe), 32'(m));
      check(32'(pinLevel & m), 32'(e & m));
      axi_rd(SOE_OFS_OUT_CTRL, 32'(c), SOE_RESP_OKAY);
    end
  endtask : t_pin_select
  task automatic t_fallback;
    @(posedge ref_clk);
    fallbackOe <= 4'h6;
    axi_wr(SOE_OFS_OUT_CTRL, 8'h00, SOE_RESP_OKAY);
    settle(1);
    check(32'(syncPinOe), 32'h6);
    axi_rd(SOE_OFS_STATUS, 32'h265, SOE_RESP_OKAY);
    fallbackOut <= 4'hA;
    settle(2);
    check(32'(syncPinOut), 32'hA);
  endtask : t_fallback
  // enables must not disturb the timer pin path; connect mode swaps in internal sync
  task automatic t_timer;
    @(posedge ref_clk);
    timerPinIn <= 6'h2A;
    syncInternal <= 4'hA;
    axi_wr(SOE_OFS_OUT_CTRL, 8'hF0, SOE_RESP_OKAY);
    settle(4);
    check(32'(timerIn), 32'h2A);
    axi_wr(SOE_OFS_IN_CTRL, 8'h20, SOE_RESP_OKAY);
    settle(1);
    check(32'(timerIn), 32'h30);
    syncInternal <= 4'h5;
    settle(2);
    check(32'(timerIn), 32'h0F);
    axi_rd(SOE_OFS_IN_CTRL, 32'h20, SOE_RESP_OKAY);
    axi_wr(SOE_OFS_IN_CTRL, 8'h00, SOE_RESP_OKAY);
    settle(4);
    check(32'(timerIn), 32'h2A);
  endtask : t_timer
  task automatic t_bus_errors;
    axi_rd(8'h0C, 32'h0, SOE_RESP_SLVERR);
    axi_wr(8'h0C, 8'hFF, SOE_RESP_SLVERR);
    axi_wr(SOE_OFS_STATUS, 8'hFF, SOE_RESP_OKAY);
    axi_rd(SOE_OFS_OUT_CTRL, 32'hF0, SOE_RESP_OKAY);
  endtask : t_bus_errors
  // mode 1 keeps the blanking pin on its address function, every other mode hands it the waveform
  task automatic t_modes;
    for (int k = 0; k < 4; k++)
    begin
      do_reset(2'(k));
      axi_wr(SOE_OFS_OUT_CTRL, 8'h11, SOE_RESP_OKAY);
      settle(1);
      check(32'(syncPinOe), 32'(4'h6 | 4'(k != 1)));
      axi_rd(SOE_OFS_STATUS, {22'h0, 2'(k), 4'h6 | 4'(k != 1), 4'hA | 4'(k != 1)},
        SOE_RESP_OKAY);
    end
  endtask : t_modes
  initial
  begin
    do_reset(2'h2);
    t_reset_values();
    t_pin_select();
    t_fallback();
    t_timer();
    t_bus_errors();
    t_modes();
    close_out();
  end
endmodule : sync_output_enable_polarity_tb_top
